// [rtl/can_wake_detect_and_pin_logic.sv]
// can transceiver pin logic with bus wake qualification
`timescale 1ns/1ns
`default_nettype none
module can_wake_detect_and_pin_logic
  import can_wake_pkg::*;
#(
  parameter int unsigned PW_MAX    = PW_MAX_CYC,    // shortest rejected long width, cycles
  parameter int unsigned GAP_MAX   = GAP_MAX_CYC,   // longest pulse spacing, cycles
  parameter int unsigned INT_PULSE = INT_PULSE_CYC  // stop wake pulse, cycles
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic                tx_bit,               // from protocol handler
  input  wire logic                bus_dominant,         // main receiver, pin
  input  wire logic                low_power_bus_receiver, // high while bus dominant, pin
  input  wire logic                wake_enable,          // bus wake allowed
  input  wire logic [1:0]          mode_sel,             // mode_e of the chip
  input  wire logic [NUM_SRC-1:0]  interrupt_enable_reg, // source enables
  input  wire logic [NUM_SRC-1:0]  int_src_set,          // other source events, pulses
  input  wire logic [NUM_SRC-1:0]  int_src_clr,          // source clear pulses
  output logic                     drive_dominant,       // bus driver on
  output logic                     rx_bit,
  output logic                     wake_flag,
  output logic                     post_wake_hold,       // hold mode after stop wake
  output logic                     int_n
);

  // clk_en low freezes every flop below, timers included,
  // so widths and gaps are counted in enabled cycles only
  // synchroniser stages
  logic [1:0]          tx_sync;
  logic [1:0]          dom_sync;
  logic [1:0]          lp_sync;
  logic                lp_prev;                 // last synced receiver level
  logic [CNT_W-1:0]    width_cnt;               // current pulse width
  logic [CNT_W-1:0]    gap_cnt;                 // time since last accepted pulse
  logic [1:0]          pulse_cnt;               // accepted pulses
  logic [CNT_W-1:0]    int_pulse_cnt;           // stop mode pulse timer
  logic [NUM_SRC-1:0]  src_pend;                // latched sources
  logic                pulse_end;
  logic                pulse_ok;
  logic                wake_hit;
  logic                in_stop;
  logic                in_active;
  logic [NUM_SRC-1:0]  src_ev;
  logic                pulse_acc;               // accepted pulse ends this cycle
  logic                stop_wake;               // wake taken while stopped

  // combinational decode of pulse end and mode
  assign pulse_end = lp_prev & ~lp_sync[1];
  assign pulse_ok  = (width_cnt >= CNT_W'(PW_MIN_CYC)) && (width_cnt < CNT_W'(PW_MAX));
  assign in_stop   = (mode_sel == MODE_STOP);
  assign in_active = (mode_sel == MODE_ACTIVE);
  assign wake_hit  = wake_enable && pulse_end && pulse_ok
                     && (pulse_cnt == 2'(WAKE_PULSES - 1)) && !in_active;
  assign pulse_acc = pulse_end && pulse_ok;
  assign stop_wake = wake_hit && in_stop;

  // two flop synchronisers for pin inputs
  // reset levels equal the idle pin levels, so no false
  // edge follows reset; only second stages feed logic
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_sync  <= 2'b11;
      dom_sync <= 2'b00;
      lp_sync  <= 2'b00;
      lp_prev  <= 1'b0;
    end else if (clk_en) begin
      tx_sync  <= {tx_sync[0], tx_bit};
      dom_sync <= {dom_sync[0], bus_dominant};
      lp_sync  <= {lp_sync[0], low_power_bus_receiver};
      lp_prev  <= lp_sync[1];
    end
  end

  // bus driver and receive output
  // one flop after the synchroniser, three cycles pin to pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drive_dominant <= 1'b0;
      rx_bit         <= 1'b1;
    end else if (clk_en) begin
      // both pins are levels, no edge logic needed
      drive_dominant <= ~tx_sync[1];
      rx_bit         <= ~dom_sync[1];
    end
  end

  // pulse width measure, saturating
  // saturation keeps an endless dominant stretch rejected
  // instead of wrapping back into the accepted window
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      width_cnt <= '0;
    end else if (clk_en) begin
      if (!lp_sync[1]) begin
        // bus recessive: next width starts from zero
        width_cnt <= '0;
      end else if (width_cnt != '1) begin
        width_cnt <= width_cnt + 1'b1;
      end
    end
  end

  // spacing timer since last accepted pulse
  // idles while no pulse is pending; the next accepted
  // pulse restarts it from zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap_cnt <= '0;
    end else if (clk_en) begin
      if (pulse_acc) begin
        // accepted pulse: spacing starts again
        gap_cnt <= '0;
      end else if (pulse_cnt != 2'd0 && gap_cnt != '1) begin
        gap_cnt <= gap_cnt + 1'b1;
      end
    end
  end

  // accepted pulse counter
  // priority: disable, reject, accept, timeout; a wake
  // returns the count to zero so a fresh burst is needed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulse_cnt <= 2'd0;
    end else if (clk_en) begin
      if (!wake_enable || in_active) begin
        // wake disabled or bus in use: nothing counts
        pulse_cnt <= 2'd0;
      end else if (pulse_end && !pulse_ok) begin
        // width outside the window: sequence dropped
        pulse_cnt <= 2'd0;
      end else if (pulse_acc) begin
        if (pulse_cnt == 2'(WAKE_PULSES - 1)) begin
          // last pulse of the burst: wake raised
          pulse_cnt <= 2'd0;
        end else begin
          // one more good pulse
          pulse_cnt <= pulse_cnt + 2'd1;
        end
      end else if (pulse_cnt != 2'd0 && gap_cnt >= CNT_W'(GAP_MAX)) begin
        // spacing too long: sequence dropped
        pulse_cnt <= 2'd0;
      end
    end
  end

  // wake flag, held until active mode
  // set wins; wake_hit is already off in active mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_flag <= 1'b0;
    end else if (clk_en) begin
      if (wake_hit) begin
        // third good pulse
        wake_flag <= 1'b1;
      end else if (in_active) begin
        // active mode ends the wake cycle
        wake_flag <= 1'b0;
      end
    end
  end

  // post wake hold mode request
  // stays up until the chip is placed in active mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      post_wake_hold <= 1'b0;
    end else if (clk_en) begin
      if (stop_wake) begin
        post_wake_hold <= 1'b1;
      end else if (in_active) begin
        // mode sequencing has taken over
        post_wake_hold <= 1'b0;
      end
    end
  end

  // stop mode interrupt pulse timer
  // pin stays low for the load cycle plus INT_PULSE cycles;
  // a new stop wake while running restarts the pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_pulse_cnt <= '0;
    end else if (clk_en) begin
      if (stop_wake) begin
        int_pulse_cnt <= CNT_W'(INT_PULSE);
      end else if (int_pulse_cnt != '0) begin
        // count the pulse down to idle
        int_pulse_cnt <= int_pulse_cnt - 1'b1;
      end
    end
  end

  // latched interrupt sources, set beats clear
  // masked events are dropped, not kept for a later enable
  assign src_ev = int_src_set
                  | ((wake_hit && !in_stop) ? NUM_SRC'(1) << SRC_WAKE : '0);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_pend <= '0;
    end else if (clk_en) begin
      src_pend <= (src_pend & ~int_src_clr) | (src_ev & interrupt_enable_reg);
    end
  end

  // interrupt pin, low for pulse or enabled pending source
  // pulse path bypasses the latch so it starts at once
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_n <= 1'b1;
    end else if (clk_en) begin
      int_n <= !((int_pulse_cnt != '0)
                 || stop_wake
                 || |(src_pend & interrupt_enable_reg));
    end
  end

endmodule : can_wake_detect_and_pin_logic
`default_nettype wire

// [rtl/can_wake_pkg.sv]
// constants for the can wake detect and pin logic block
// Function
// - tx low drives dominant, high recessive
// - rx low when dominant, high recessive
// - accept pulses wider 0.5us, narrower 500us
// - rejected pulse clears counter, no wake
// - count accepted pulses, wake at three
// - gap over 500us clears counter
// - wake flag holds until active mode
// - enable input disables bus wake entirely
// - stop mode wake gives 10us low pulse
// - otherwise int low until source cleared
// - only enabled sources assert interrupt (the stop mode wake pulse drives int_n regardless of interrupt_enable_reg)
// - stop wake moves to post-wake hold mode
package can_wake_pkg;
  localparam int unsigned CLK_MHZ         = 125;           // clock rate in MHz
  localparam int unsigned PW_MIN_NS       = 500;           // 0.5 us least width
  localparam int unsigned PW_MAX_US       = 500;           // shortest rejected long width
  localparam int unsigned GAP_MAX_US      = 500;           // longest spacing
  localparam int unsigned INT_PULSE_US    = 10;            // stop mode pulse
  localparam int unsigned PW_MIN_CYC      = (PW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PW_MAX_CYC      = PW_MAX_US * CLK_MHZ;
  localparam int unsigned GAP_MAX_CYC     = GAP_MAX_US * CLK_MHZ;
  localparam int unsigned INT_PULSE_CYC   = INT_PULSE_US * CLK_MHZ;
  localparam int unsigned WAKE_PULSES     = 3;             // pulses for a wake
  localparam int unsigned CNT_W           = 17;            // timer width
  localparam int unsigned NUM_SRC         = 8;             // interrupt sources
  localparam int unsigned SRC_WAKE        = 0;             // wake source bit
  typedef enum logic [1:0] {
    MODE_OTHER  = 2'b00,
    MODE_STOP   = 2'b01,
    MODE_ACTIVE = 2'b10
  } mode_e;
endpackage : can_wake_pkg

// [dv/can_wake_properties.sv]
// port checker for the can wake detect and pin logic
`timescale 1ns/1ns
`default_nettype none
module can_wake_properties
  import can_wake_pkg::*;
#(
  parameter int unsigned INT_PULSE = INT_PULSE_CYC  // stop wake pulse, cycles
) (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               clk_en,
  input wire logic               tx_bit,
  input wire logic               bus_dominant,
  input wire logic               wake_enable,
  input wire logic               drive_dominant,
  input wire logic               rx_bit,
  input wire logic               wake_flag,
  input wire logic               post_wake_hold,
  input wire logic               int_n,
  input wire logic [1:0]         mode_sel,
  input wire logic [NUM_SRC-1:0] interrupt_enable_reg,
  input wire logic [NUM_SRC-1:0] int_src_clr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !clk_en);  // frozen cycles prove nothing
  int unsigned lowc;  // length of the current low stretch of int_n
  always_ff @(posedge clk_sys) lowc <= int_n ? 0 : lowc + 1;
  sequence s_held_active;  // mode held active long enough to clear
    (mode_sel == MODE_ACTIVE) [*3];
  endsequence
  a_tx_low_dom: assert property ((!tx_bit) [*4] |-> drive_dominant) else $error("tx low not dominant");
  a_tx_high_rec: assert property (tx_bit [*4] |-> !drive_dominant) else $error("tx high not recessive");
  a_rx_dom_low: assert property (bus_dominant [*4] |-> !rx_bit) else $error("rx not low");
  a_rx_rec_high: assert property ((!bus_dominant) [*4] |-> rx_bit) else $error("rx not high");
  a_flag_holds: assert property (wake_flag && mode_sel != MODE_ACTIVE |=> wake_flag) else $error("flag lost");
  a_flag_clears: assert property (s_held_active |-> !wake_flag) else $error("flag kept");
  a_wake_enabled: assert property ($rose(wake_flag) |-> $past(wake_enable)) else $error("wake while off");
  a_stop_hold: assert property ($rose(wake_flag) && mode_sel == MODE_STOP |-> ##[0:2] post_wake_hold)
    else $error("no hold mode");
  a_stop_width: assert property ($rose(int_n) && post_wake_hold |-> lowc == INT_PULSE + 1)
    else $error("bad stop pulse");
  a_int_pending: assert property (!int_n && !post_wake_hold && int_src_clr == 8'h00 |=> !int_n)
    else $error("int released early");
  a_int_gated: assert property ($fell(int_n) && mode_sel != MODE_STOP |-> $past(interrupt_enable_reg) != 8'h00)
    else $error("int with no enable");
endmodule : can_wake_properties
bind can_wake_detect_and_pin_logic can_wake_properties #(.INT_PULSE(INT_PULSE)) can_wake_properties_inst (.*);
`default_nettype wire

// [dv/mcu_model.sv]
// protocol handler and interrupt input of the microcontroller
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
  input wire logic clk_sys, tx_req, int_n,
  output logic tx_bit,
  output var int int_low = 0  // total cycles seen with int_n low
);
  always @(posedge clk_sys) tx_bit <= tx_req;  // handler output flop
  always @(posedge clk_sys) if (int_n === 1'b0) int_low <= int_low + 1;
endmodule : mcu_model
`default_nettype wire

// [dv/can_wake_detect_and_pin_logic_bench.sv]
// bench for the can wake detect and pin logic
`timescale 1ns/1ns
`default_nettype none
module can_wake_detect_and_pin_logic_bench;
  import can_wake_pkg::*;
  localparam int unsigned IPL = 20;  // short stop pulse
  logic clk_sys = 0, rst = 1, clk_en = 1, tx_req = 1, bus_dominant = 0, low_power_bus_receiver = 0, wake_enable = 1;
  logic [1:0] mode_sel = MODE_OTHER;
  logic [7:0] interrupt_enable_reg = 8'h01, int_src_set = 8'h00, int_src_clr = 8'h00;
  logic tx_bit, drive_dominant, rx_bit, wake_flag, post_wake_hold, int_n;
  int n_errors = 0, cmp_count = 0, int_low, k;
  int wm[7] = '{100, 62, 63, 199, 200, 100, 100};  // middle pulse width
  int gm[7] = '{100, 100, 100, 100, 100, 350, 100};  // gap after it
  logic ex[7] = '{1, 0, 1, 1, 0, 0, 0};  // wake expected
  initial forever #4 clk_sys = ~clk_sys;
  mcu_model mcu_model_inst (.clk_sys(clk_sys), .tx_req(tx_req), .int_n(int_n), .tx_bit(tx_bit), .int_low(int_low));
  can_wake_detect_and_pin_logic #(.PW_MAX(200), .GAP_MAX(400), .INT_PULSE(IPL))
    can_wake_detect_and_pin_logic_inst (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .tx_bit(tx_bit), .bus_dominant(bus_dominant),
    .low_power_bus_receiver(low_power_bus_receiver), .wake_enable(wake_enable), .mode_sel(mode_sel),
    .interrupt_enable_reg(interrupt_enable_reg), .int_src_set(int_src_set), .int_src_clr(int_src_clr),
    .drive_dominant(drive_dominant), .rx_bit(rx_bit), .wake_flag(wake_flag),
    .post_wake_hold(post_wake_hold), .int_n(int_n));
  // seen is taken at the edge: the value settled before it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic pulse(input int w, input int g);
    low_power_bus_receiver <= 1;
    cyc(w);
    low_power_bus_receiver <= 0;
    cyc(g);
  endtask : pulse
  task automatic burst(input int w, input int g);
    pulse(100, 100);
    pulse(w, g);
    pulse(100, 12);
  endtask : burst
  task automatic go_clear();  // active mode and clear of all sources
    mode_sel <= MODE_ACTIVE;
    int_src_clr <= 8'hff;
    cyc(4);
    int_src_clr <= 8'h00;
    mode_sel <= MODE_OTHER;
    cyc(2);
  endtask : go_clear
  task automatic t_pins();  // every pin pairing
    for (int i = 0; i < 4; i++) begin
      tx_req <= i[0];
      bus_dominant <= i[1];
      cyc(6);
      check(drive_dominant, !i[0]);
      check(rx_bit, !i[1]);
    end
    tx_req <= 1;
  endtask : t_pins
  task automatic t_filter();  // widths, spacing and enable boundaries
    for (int i = 0; i < 7; i++) begin
      wake_enable <= (i != 6);
      burst(wm[i], gm[i]);
      check(wake_flag, ex[i]);
      check(int_n, !ex[i]);
      cyc(30);
      check(wake_flag, ex[i]);
      go_clear();
      check(wake_flag, 0);
      check(int_n, 1);
    end
    wake_enable <= 1;
  endtask : t_filter
  task automatic t_ints();  // masked then enabled source
    interrupt_enable_reg <= 8'h00;
    int_src_set <= 8'h08;
    cyc(1);
    int_src_set <= 8'h00;
    cyc(4);
    check(int_n, 1);
    interrupt_enable_reg <= 8'h08;
    int_src_set <= 8'h08;
    cyc(1);
    int_src_set <= 8'h00;
    cyc(4);
    check(int_n, 0);
    go_clear();
    check(int_n, 1);
    interrupt_enable_reg <= 8'h01;
  endtask : t_ints
  task automatic t_stop();  // stop mode wake pulse and hold mode
    mode_sel <= MODE_STOP;
    k = int_low;
    burst(100, 100);
    check(post_wake_hold, 1);
    for (int i = 0; i <= 100 && int_n !== 1'b1; i++) cyc(1);
    if (int_n !== 1'b1) n_errors++;  // pulse never ended
    cyc(2);
    check(8'(int_low - k), 8'(IPL + 1));
    check(post_wake_hold, 1);
    go_clear();
    check(post_wake_hold, 0);
  endtask : t_stop
  task automatic t_freeze();  // clk_en low holds the driver
    clk_en <= 0;
    tx_req <= 0;
    cyc(8);
    check(drive_dominant, 0);
    clk_en <= 1;
    cyc(6);
    check(drive_dominant, 1);
    tx_req <= 1;
    cyc(6);
    check(drive_dominant, 0);
  endtask : t_freeze
  task automatic t_reset();  // reset in mid-run with a wake pending
    tx_req <= 0;
    bus_dominant <= 1;
    burst(100, 100);
    check(wake_flag, 1);
    rst <= 1;
    cyc(2);
    check(wake_flag, 0);
    check(int_n, 1);
    check(drive_dominant, 0);
    check(rx_bit, 1);
    check(post_wake_hold, 0);
    rst <= 0;
    cyc(6);
    check(drive_dominant, 1);
    check(rx_bit, 0);
    check(int_n, 1);
    tx_req <= 1;
    bus_dominant <= 0;
    cyc(6);
  endtask : t_reset
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    cyc(5);
    rst <= 0;
    cyc(3);
    t_pins();
    t_filter();
    t_ints();
    t_stop();
    t_freeze();
    t_reset();
    summarize();
  end
endmodule : can_wake_detect_and_pin_logic_bench
`default_nettype wire
